/* File: common/lpmarb_pkg.sv */
// Purpose: Constants and types for the low-power mode entry arbiter
// Assumes: 100 MHz i_ref_clk, APB with 32-bit data
// Notes:   Mode codes grow with depth so that demotion is a minimum
//
// Notes on behaviour
// - Clock above 50 kHz: high-frequency.
// - Clock at or below 50 kHz: low-frequency.
// - No internal clock: unclocked.
// - Unsupported request enters a mode that supports all peripherals.
// - DMA transfers only when active, waits in any mode below shutdown.
// - DMA trigger goes active for the transfer, then returns.
// - Busy checksum, multiplier or cipher postpones entry.
// - Timer: sub-main or fast external is HF, aux LF, slow external unclocked.
// - UART: sub-main HF, aux LF, unclocked while awaiting a start edge.
// - I2C target unclocked while awaiting START or on slow external clock.
// - Converter: sub-main or module oscillator HF, aux LF, unclocked awaiting trigger.
// - Display and calendar are only ever low-frequency.
// - Scan interface: sub-main HF, aux or scan oscillator LF, never unclocked.
// - FRAM-off wake adds latency only when the wake needs FRAM.
// - Interrupt wakes modes one to five, then returns.
// - Shutdown drops core supply; wake resets core and peripherals.
`default_nettype none
package lpmarb_pkg;
    localparam int NSLOT = 8;
    localparam logic [2:0] MODE_ACTIVE = 3'h0;
    localparam logic [2:0] MODE_CPU_OFF = 3'h1;
    localparam logic [2:0] MODE_CPU_OFF_SLOW = 3'h2;
    localparam logic [2:0] MODE_STBY_FAST = 3'h3;
    localparam logic [2:0] MODE_STANDBY = 3'h4;
    localparam logic [2:0] MODE_ALL_OFF = 3'h5;
    localparam logic [2:0] MODE_CAL_SHUT = 3'h6;
    localparam logic [2:0] MODE_FULL_SHUT = 3'h7;
    // Peripheral kinds
    localparam logic [2:0] K_GENERIC = 3'h0;
    localparam logic [2:0] K_TIMER = 3'h1;
    localparam logic [2:0] K_UART = 3'h2;
    localparam logic [2:0] K_I2C_TGT = 3'h3;
    localparam logic [2:0] K_CONV = 3'h4;
    localparam logic [2:0] K_DISPLAY = 3'h5;
    localparam logic [2:0] K_CALENDAR = 3'h6;
    localparam logic [2:0] K_SCAN = 3'h7;
    // Clock sources
    localparam logic [2:0] C_NONE = 3'h0;
    localparam logic [2:0] C_SUB_MAIN = 3'h1;
    localparam logic [2:0] C_AUX = 3'h2;
    localparam logic [2:0] C_EXT = 3'h3;
    localparam logic [2:0] C_MOD_OSC = 3'h4;
    localparam logic [2:0] C_VLO = 3'h5;
    localparam logic [2:0] C_LOW_FREQ_CRYSTAL_CLOCK = 3'h6;
    localparam logic [2:0] C_SCAN_OSC = 3'h7;
    localparam logic [7:0] LF_MAX_KHZ = 8'h32;
    typedef enum logic [1:0] {LPMARB_IDLE, LPMARB_UNCLK, LPMARB_LF, LPMARB_HF} lpmarb_cls_t;
    typedef enum logic [2:0] {S_ACTIVE, S_POSTPONE, S_LOW, S_DMA, S_FWAKE, S_IRQ, S_SHUT} lpmarb_st_t;
    // Register map
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_SLOT0 = 8'h10;
    localparam logic [7:0] A_SLOT_END = 8'h30;
    localparam int F_FRAM_OFF = 3;
    localparam int F_DEMOTED = 6;
    localparam int F_POSTPONED = 7;
    localparam int F_LIMIT = 8;
    localparam int F_KIND = 0;
    localparam int F_SRC = 3;
    localparam int F_EN = 6;
    localparam int F_KHZ = 8;
    localparam logic [15:0] SLOT_RST = 16'h0000;
    // FRAM wake latency
    localparam int FRAM_WAKE_NS = 1000;
    localparam int CLK_NS = 10;
    localparam int FRAM_WAKE_CYC = (FRAM_WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int FW = 8;
endpackage : lpmarb_pkg
`default_nettype wire

/* File: src/lpmarb_sync.sv */
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are levels from outside the clock domain
// Notes:   Only the second stage is read outside
`default_nettype none
module lpmarb_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // Data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } lpmarb_sync_t;
    lpmarb_sync_t st_r;
    lpmarb_sync_t st_nxt;
    always_comb begin
        st_nxt.s1 = i_d;
        st_nxt.s2 = st_r.s1;
    end
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign o_q = st_r.s2;
endmodule : lpmarb_sync
`default_nettype wire

/* File: src/lpmarb_classify.sv */
// Purpose: Classify one peripheral slot by clock source and kind
// Assumes: Slot fields come from a software-written register
// Notes:   Purely combinational; external clocks flagged separately
`default_nettype none
module lpmarb_classify (
    // Slot configuration
    input wire logic [2:0] i_kind,
    input wire logic [2:0] i_src,
    input wire logic [7:0] i_khz,
    input wire logic i_en,
    input wire logic i_waiting,
    // Result
    output lpmarb_pkg::lpmarb_cls_t o_cls,
    output logic o_ext
);
    lpmarb_pkg::lpmarb_cls_t base;
    logic fast_ext;
    always_comb begin
        fast_ext = (i_khz > lpmarb_pkg::LF_MAX_KHZ);
        case (i_src)
            lpmarb_pkg::C_SUB_MAIN, lpmarb_pkg::C_MOD_OSC: base = lpmarb_pkg::LPMARB_HF;
            lpmarb_pkg::C_AUX, lpmarb_pkg::C_VLO, lpmarb_pkg::C_LOW_FREQ_CRYSTAL_CLOCK,
            lpmarb_pkg::C_SCAN_OSC: base = lpmarb_pkg::LPMARB_LF;
            lpmarb_pkg::C_EXT: base = fast_ext ? lpmarb_pkg::LPMARB_HF : lpmarb_pkg::LPMARB_LF;
            default: base = lpmarb_pkg::LPMARB_UNCLK;
        endcase
        o_cls = base;
        case (i_kind)
            lpmarb_pkg::K_TIMER: begin
                if (i_src == lpmarb_pkg::C_EXT && !fast_ext) begin
                    o_cls = lpmarb_pkg::LPMARB_UNCLK;
                end
            end
            lpmarb_pkg::K_UART, lpmarb_pkg::K_CONV: begin
                if (i_waiting) begin
                    o_cls = lpmarb_pkg::LPMARB_UNCLK;
                end
            end
            lpmarb_pkg::K_I2C_TGT: begin
                if (i_waiting || (i_src == lpmarb_pkg::C_EXT && !fast_ext)) begin
                    o_cls = lpmarb_pkg::LPMARB_UNCLK;
                end
            end
            lpmarb_pkg::K_DISPLAY, lpmarb_pkg::K_CALENDAR: o_cls = lpmarb_pkg::LPMARB_LF;
            lpmarb_pkg::K_SCAN: begin
                if (base != lpmarb_pkg::LPMARB_HF) begin
                    o_cls = lpmarb_pkg::LPMARB_LF;
                end
            end
            default: o_cls = base;
        endcase
        if (!i_en) begin
            o_cls = lpmarb_pkg::LPMARB_IDLE;
        end
        o_ext = i_en && (i_src == lpmarb_pkg::C_EXT);
    end
endmodule : lpmarb_classify
`default_nettype wire

/* File: src/lpmarb_top.sv */
// Purpose: Low-power mode entry arbiter with APB register access
// Assumes: Busy, waiting, done and return inputs share i_ref_clk
// Notes:   Wake pins pass a two-stage synchroniser first
//
// The implementer's own choices: the register addresses and register access over APB.
`default_nettype none
module lpmarb_top (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Peripheral status
    input wire logic [lpmarb_pkg::NSLOT-1:0] i_periph_waiting,
    input wire logic i_crc_busy,
    input wire logic i_mpy_busy,
    input wire logic i_aes_busy,
    input wire logic i_dma_done,
    input wire logic i_irq_return,
    // Pins from outside the domain
    input wire logic i_dma_trig,
    input wire logic i_wake_event,
    // Power control
    output logic [2:0] o_mode,
    output logic o_cpu_run,
    output logic o_fram_on,
    output logic o_fast_clk_en,
    output logic o_aux_clk_en,
    output logic o_core_supply_on,
    output logic o_core_reset,
    output logic o_dma_go
);
    // ********
    // State
    // ********
    typedef struct packed {
        lpmarb_pkg::lpmarb_st_t st;
        logic [2:0] req;
        logic [2:0] mode;
        logic [2:0] lim;
        logic fram_off;
        logic demoted;
        logic postponed;
        logic [lpmarb_pkg::NSLOT-1:0][15:0] slot;
        logic [lpmarb_pkg::FW-1:0] fcnt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic cpu_run;
        logic fram_on;
        logic fast_en;
        logic aux_en;
        logic supply_on;
        logic core_reset;
        logic dma_go;
    } lpmarb_state_t;

    lpmarb_state_t st_r;
    lpmarb_state_t st_nxt;

    // ********
    // Pin synchronisers
    // ********
    logic [1:0] pins_q;
    logic dma_trig_s;
    logic wake_s;

    lpmarb_sync #(
        .W(2)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_d({i_dma_trig, i_wake_event}),
        .o_q(pins_q)
    );
    assign dma_trig_s = pins_q[1];
    assign wake_s = pins_q[0];

    // ********
    // Peripheral classification
    // ********
    lpmarb_pkg::lpmarb_cls_t cls [lpmarb_pkg::NSLOT];
    logic [lpmarb_pkg::NSLOT-1:0] ext;
    logic [lpmarb_pkg::NSLOT-1:0] is_hf;
    logic [lpmarb_pkg::NSLOT-1:0] is_lf;
    logic [lpmarb_pkg::NSLOT-1:0] is_uc;

    genvar gi;
    generate
        for (gi = 0; gi < lpmarb_pkg::NSLOT; gi++) begin : g_slot
            lpmarb_classify u_cls (
                .i_kind(st_r.slot[gi][lpmarb_pkg::F_KIND +: 3]),
                .i_src(st_r.slot[gi][lpmarb_pkg::F_SRC +: 3]),
                .i_khz(st_r.slot[gi][lpmarb_pkg::F_KHZ +: 8]),
                .i_en(st_r.slot[gi][lpmarb_pkg::F_EN]),
                .i_waiting(i_periph_waiting[gi]),
                .o_cls(cls[gi]),
                .o_ext(ext[gi])
            );
            // External clocks never force a shallower mode
            assign is_hf[gi] = !ext[gi] && cls[gi] == lpmarb_pkg::LPMARB_HF;
            assign is_lf[gi] = !ext[gi] && cls[gi] == lpmarb_pkg::LPMARB_LF;
            assign is_uc[gi] = !ext[gi] && cls[gi] == lpmarb_pkg::LPMARB_UNCLK;
        end
    endgenerate

    // ********
    // Deepest permitted mode
    // ********
    logic [2:0] limit;
    logic busy;

    always_comb begin
        if (|is_hf) begin
            limit = lpmarb_pkg::MODE_CPU_OFF_SLOW;
        end else if (|is_lf) begin
            limit = lpmarb_pkg::MODE_STANDBY;
        end else if (|is_uc) begin
            limit = lpmarb_pkg::MODE_ALL_OFF;
        end else begin
            limit = lpmarb_pkg::MODE_FULL_SHUT;
        end
    end

    assign busy = i_crc_busy || i_mpy_busy || i_aes_busy;

    function automatic logic [2:0] grant(input logic [2:0] req, input logic [2:0] lim);
        grant = (req > lim) ? lim : req;
    endfunction : grant

    // ********
    // APB decode
    // ********
    logic setup;
    logic wr_acc;
    logic mapped;
    logic is_slot;
    logic [2:0] slot_idx;
    logic [7:0] slot_off;

    assign setup = i_psel && !i_penable;
    assign wr_acc = i_psel && i_penable && st_r.pready && i_pwrite && !st_r.pslverr;
    assign slot_off = i_paddr - lpmarb_pkg::A_SLOT0;
    assign slot_idx = slot_off[4:2];
    assign is_slot = i_paddr >= lpmarb_pkg::A_SLOT0 && i_paddr < lpmarb_pkg::A_SLOT_END
        && i_paddr[1:0] == 2'h0;
    assign mapped = i_paddr == lpmarb_pkg::A_CTRL || i_paddr == lpmarb_pkg::A_STATUS || is_slot;

    // ********
    // Next state
    // ********
    logic req_new;
    logic [2:0] eff;

    always_comb begin
        st_nxt = st_r;
        req_new = 1'b0;
        st_nxt.core_reset = 1'b0;
        st_nxt.lim = limit;

        // Bus answer one cycle after setup
        st_nxt.pready = setup;
        st_nxt.pslverr = setup && !mapped;
        if (setup) begin
            st_nxt.prdata = 32'h0000_0000;
            if (i_paddr == lpmarb_pkg::A_CTRL) begin
                st_nxt.prdata[2:0] = st_r.req;
                st_nxt.prdata[lpmarb_pkg::F_FRAM_OFF] = st_r.fram_off;
            end else if (i_paddr == lpmarb_pkg::A_STATUS) begin
                st_nxt.prdata[2:0] = st_r.mode;
                st_nxt.prdata[lpmarb_pkg::F_DEMOTED] = st_r.demoted;
                st_nxt.prdata[lpmarb_pkg::F_POSTPONED] = st_r.postponed;
                st_nxt.prdata[lpmarb_pkg::F_LIMIT +: 3] = st_r.lim;
            end else if (is_slot) begin
                st_nxt.prdata[15:0] = st_r.slot[slot_idx];
            end
        end

        if (wr_acc) begin
            if (i_paddr == lpmarb_pkg::A_CTRL) begin
                st_nxt.req = i_pwdata[2:0];
                st_nxt.fram_off = i_pwdata[lpmarb_pkg::F_FRAM_OFF];
                req_new = 1'b1;
            end else if (i_paddr == lpmarb_pkg::A_STATUS) begin
                if (i_pwdata[lpmarb_pkg::F_DEMOTED]) begin
                    st_nxt.demoted = 1'b0;
                end
            end else begin
                st_nxt.slot[slot_idx] = i_pwdata[15:0];
            end
        end

        eff = grant(st_r.req, limit);

        case (st_r.st)
            lpmarb_pkg::S_ACTIVE: begin
                st_nxt.mode = lpmarb_pkg::MODE_ACTIVE;
                if (req_new && i_pwdata[2:0] != lpmarb_pkg::MODE_ACTIVE) begin
                    st_nxt.st = lpmarb_pkg::S_POSTPONE;
                end
            end
            lpmarb_pkg::S_POSTPONE: begin
                st_nxt.postponed = busy;
                if (st_r.req == lpmarb_pkg::MODE_ACTIVE) begin
                    st_nxt.st = lpmarb_pkg::S_ACTIVE;
                end else if (!busy) begin
                    st_nxt.mode = eff;
                    if (eff != st_r.req) begin
                        st_nxt.demoted = 1'b1;
                    end
                    if (eff >= lpmarb_pkg::MODE_CAL_SHUT) begin
                        st_nxt.st = lpmarb_pkg::S_SHUT;
                    end else begin
                        st_nxt.st = lpmarb_pkg::S_LOW;
                    end
                end
            end
            lpmarb_pkg::S_LOW: begin
                // Interrupt takes priority over a DMA trigger
                if (wake_s) begin
                    if (st_r.fram_off) begin
                        st_nxt.st = lpmarb_pkg::S_FWAKE;
                        st_nxt.fcnt = lpmarb_pkg::FW'(lpmarb_pkg::FRAM_WAKE_CYC - 1);
                    end else begin
                        st_nxt.st = lpmarb_pkg::S_IRQ;
                    end
                end else if (dma_trig_s) begin
                    st_nxt.st = lpmarb_pkg::S_DMA;
                end
            end
            lpmarb_pkg::S_DMA: begin
                // Transfer to RAM needs no FRAM, so no wake delay
                if (i_dma_done) begin
                    st_nxt.st = lpmarb_pkg::S_LOW;
                end
            end
            lpmarb_pkg::S_FWAKE: begin
                if (st_r.fcnt == '0) begin
                    st_nxt.st = lpmarb_pkg::S_IRQ;
                end else begin
                    st_nxt.fcnt = st_r.fcnt - 1'b1;
                end
            end
            lpmarb_pkg::S_IRQ: begin
                if (i_irq_return) begin
                    st_nxt.st = lpmarb_pkg::S_POSTPONE;
                end
            end
            lpmarb_pkg::S_SHUT: begin
                if (wake_s) begin
                    // Core comes back from reset; slot setup is lost
                    st_nxt.st = lpmarb_pkg::S_ACTIVE;
                    st_nxt.core_reset = 1'b1;
                    st_nxt.req = lpmarb_pkg::MODE_ACTIVE;
                    st_nxt.mode = lpmarb_pkg::MODE_ACTIVE;
                    st_nxt.fram_off = 1'b0;
                    for (int k = 0; k < lpmarb_pkg::NSLOT; k++) begin
                        st_nxt.slot[k] = lpmarb_pkg::SLOT_RST;
                    end
                end
            end
            default: st_nxt.st = lpmarb_pkg::S_ACTIVE;
        endcase

        // Mode-derived controls, registered for clean outputs
        case (st_nxt.st)
            lpmarb_pkg::S_ACTIVE, lpmarb_pkg::S_POSTPONE, lpmarb_pkg::S_IRQ: begin
                st_nxt.cpu_run = 1'b1;
                st_nxt.fram_on = 1'b1;
                st_nxt.fast_en = 1'b1;
                st_nxt.aux_en = 1'b1;
                st_nxt.supply_on = 1'b1;
                st_nxt.dma_go = 1'b1;
            end
            lpmarb_pkg::S_DMA: begin
                st_nxt.cpu_run = 1'b0;
                st_nxt.fram_on = !st_r.fram_off;
                st_nxt.fast_en = 1'b1;
                st_nxt.aux_en = 1'b1;
                st_nxt.supply_on = 1'b1;
                st_nxt.dma_go = 1'b1;
            end
            lpmarb_pkg::S_FWAKE: begin
                st_nxt.cpu_run = 1'b0;
                st_nxt.fram_on = 1'b1;
                st_nxt.fast_en = 1'b1;
                st_nxt.aux_en = 1'b1;
                st_nxt.supply_on = 1'b1;
                st_nxt.dma_go = 1'b0;
            end
            default: begin
                // Low-power and shutdown: DMA idle; only low-power waits for a trigger, shutdown ignores it
                st_nxt.cpu_run = 1'b0;
                st_nxt.fram_on = st_nxt.mode == lpmarb_pkg::MODE_CPU_OFF && !st_r.fram_off;
                st_nxt.fast_en = st_nxt.mode <= lpmarb_pkg::MODE_CPU_OFF_SLOW;
                st_nxt.aux_en = st_nxt.mode <= lpmarb_pkg::MODE_STANDBY;
                st_nxt.supply_on = st_nxt.mode < lpmarb_pkg::MODE_CAL_SHUT;
                st_nxt.dma_go = 1'b0;
            end
        endcase
    end

    // ********
    // Registers
    // ********
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= '0;
            st_r.st <= lpmarb_pkg::S_ACTIVE;
            st_r.lim <= lpmarb_pkg::MODE_FULL_SHUT;
            st_r.cpu_run <= 1'b1;
            st_r.fram_on <= 1'b1;
            st_r.fast_en <= 1'b1;
            st_r.aux_en <= 1'b1;
            st_r.supply_on <= 1'b1;
            st_r.dma_go <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_prdata = st_r.prdata;
    assign o_pready = st_r.pready;
    assign o_pslverr = st_r.pslverr;
    assign o_mode = st_r.mode;
    assign o_cpu_run = st_r.cpu_run;
    assign o_fram_on = st_r.fram_on;
    assign o_fast_clk_en = st_r.fast_en;
    assign o_aux_clk_en = st_r.aux_en;
    assign o_core_supply_on = st_r.supply_on;
    assign o_core_reset = st_r.core_reset;
    assign o_dma_go = st_r.dma_go;
endmodule : lpmarb_top
`default_nettype wire

/* File: tb/lpmarb_assertions.sv */
// Purpose: Port-level checks for the mode entry arbiter
// Assumes: Only the top module's ports are seen
// Notes:   One clock domain, so default clocking
`default_nettype none
module lpmarb_assertions (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // APB
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    // Status and pins
    input wire logic i_crc_busy,
    input wire logic i_mpy_busy,
    input wire logic i_aes_busy,
    input wire logic i_dma_done,
    input wire logic i_dma_trig,
    input wire logic i_wake_event,
    // Power control
    input wire logic [2:0] o_mode,
    input wire logic o_cpu_run,
    input wire logic o_fram_on,
    input wire logic o_fast_clk_en,
    input wire logic o_core_supply_on,
    input wire logic o_core_reset,
    input wire logic o_dma_go
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);
    // ********
    // Checks
    // ********
    busy_hold_a: assert property ((i_crc_busy || i_mpy_busy || i_aes_busy) && o_mode == 3'h0 && o_cpu_run
        |=> o_mode == 3'h0) else $error("entry while busy");
    dma_fast_a: assert property (o_dma_go |-> o_fast_clk_en) else $error("dma slow clock");
    dma_end_a: assert property (o_dma_go && !o_cpu_run && i_dma_done |-> ##[1:3] !o_dma_go)
        else $error("dma not ended");
    dma_wake_a: assert property ($rose(i_dma_trig) && o_mode != 3'h0 && !o_cpu_run && o_core_supply_on
        && !i_wake_event |-> ##[1:8] o_dma_go) else $error("dma wake slow");
    sleep_fast_a: assert property (o_mode >= 3'h4 && $stable(o_mode) && !o_cpu_run && !o_dma_go
        && !o_fram_on |-> !o_fast_clk_en) else $error("fast clock in standby");
    shut_supply_a: assert property ($fell(o_core_supply_on) |-> o_mode >= 3'h6)
        else $error("supply drop outside shutdown");
    wake_reset_a: assert property (o_core_reset |=> !o_core_reset && o_mode == 3'h0)
        else $error("core reset too long");
    cpu_wake_a: assert property ($rose(i_wake_event) && o_mode != 3'h0 && o_mode < 3'h6 && !o_cpu_run
        && !o_dma_go |-> ##[1:130] o_cpu_run) else $error("no interrupt wake");
    pready_setup_a: assert property (i_psel && !i_penable |=> o_pready) else $error("no setup answer");
    pready_once_a: assert property (o_pready |=> !o_pready) else $error("ready too long");
endmodule : lpmarb_assertions
bind lpmarb_top lpmarb_assertions i_chk (.i_ref_clk, .i_resetn, .i_psel, .i_penable, .o_pready, .i_crc_busy,
    .i_mpy_busy, .i_aes_busy, .i_dma_done, .i_dma_trig, .i_wake_event, .o_mode, .o_cpu_run, .o_fram_on,
    .o_fast_clk_en, .o_core_supply_on, .o_core_reset, .o_dma_go);
`default_nettype wire

/* File: tb/lpmarb_partner.sv */
// Purpose: Core and peripheral model answering wakes and DMA
// Assumes: Same clock as the arbiter
// Notes:   i_slow stretches every answer
`default_nettype none
module lpmarb_partner (
    // Clock and mode
    input wire logic i_ref_clk,
    input wire logic i_slow,
    // From arbiter
    input wire logic i_cpu_run,
    input wire logic i_dma_go,
    // To arbiter
    output logic o_irq_return,
    output logic o_dma_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_irq = 0;
    int cnt_dma = 0;
    initial o_irq_return = 1'b0;
    initial o_dma_done = 1'b0;
    always @(posedge i_ref_clk) begin
        cnt_irq <= i_cpu_run ? cnt_irq + 1 : 0;
        cnt_dma <= i_dma_go ? cnt_dma + 1 : 0;
        o_irq_return <= (cnt_irq == (i_slow ? 30 : 6));
        o_dma_done <= (cnt_dma == (i_slow ? 30 : 3));
    end
endmodule : lpmarb_partner
`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the mode entry arbiter
// Assumes: Partner model answers wakes and DMA
// Notes:   Reads are judged by a separate monitor
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk, i_resetn, i_psel, i_penable, i_pwrite, i_crc_busy, i_mpy_busy, i_aes_busy, slow;
    logic i_dma_done, i_irq_return, i_dma_trig, i_wake_event, o_pready, o_pslverr, o_cpu_run, o_fram_on;
    logic o_fast_clk_en, o_aux_clk_en, o_core_supply_on, o_core_reset, o_dma_go;
    logic [7:0] i_paddr, i_periph_waiting;
    logic [31:0] i_pwdata, o_prdata;
    logic [2:0] o_mode;
    logic [15:0] v;
    logic [32:0] exp_q[$], msk_q[$];
    int mismatches, check_count, n, s;
    logic [19:0] tbl[16] = '{20'h20048, 20'h40050, 20'h50040, 20'h70008,
        20'h20049, 20'h73359, 20'h40051, 20'hD004A,
        20'h40052, 20'hD0053, 20'h20064, 20'hD0054,
        20'h4006D, 20'h40076, 20'h4007F, 20'hA004F};
    lpmarb_top i_dut (.i_ref_clk, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
        .o_pready, .o_pslverr, .i_periph_waiting, .i_crc_busy, .i_mpy_busy, .i_aes_busy, .i_dma_done,
        .i_irq_return, .i_dma_trig, .i_wake_event, .o_mode, .o_cpu_run, .o_fram_on, .o_fast_clk_en,
        .o_aux_clk_en, .o_core_supply_on, .o_core_reset, .o_dma_go);
    lpmarb_partner i_core (.i_ref_clk, .i_slow(slow), .i_cpu_run(o_cpu_run), .i_dma_go(o_dma_go),
        .o_irq_return(i_irq_return), .o_dma_done(i_dma_done));
    task automatic check(input logic [32:0] seen, input logic [32:0] want, input string what);
        check_count++;
        if (seen !== want) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", what, want, seen);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        do @(posedge i_ref_clk); while (o_pready !== 1'b1);
        {i_psel, i_penable} <= 2'b00;
        @(posedge i_ref_clk);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [32:0] want, input logic [32:0] msk);
        exp_q.push_back(want);
        msk_q.push_back(msk);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic wait_hi(ref logic sig);
        n = 0;
        while (sig !== 1'b1 && n < 300) begin
            @(posedge i_ref_clk);
            n++;
        end
    endtask : wait_hi
    task automatic wait_mode(input logic [2:0] m);
        for (s = 0; s < 300 && o_mode !== m; s++) @(posedge i_ref_clk);
        check(33'(o_mode), 33'(m), "granted mode");
    endtask : wait_mode
    task automatic pulse(input logic dma);
        {i_dma_trig, i_wake_event} <= {dma, !dma};
        repeat (3) @(posedge i_ref_clk);
        {i_dma_trig, i_wake_event} <= 2'b00;
    endtask : pulse
    task automatic to_active();
        apb(1'b1, 8'h00, 32'h0);
        pulse(1'b0);
        repeat (150) @(posedge i_ref_clk);
        wait_mode(3'h0);
    endtask : to_active
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    always @(posedge i_ref_clk) begin
        if (i_psel && i_penable && o_pready && !i_pwrite && exp_q.size() > 0) begin
            check({o_pslverr, o_prdata} & msk_q.pop_front(), exp_q.pop_front(), "read data");
        end
    end
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        mismatches++;
        results();
    end
    // ***********
    // Scenarios
    // ***********
    initial begin
        {i_psel, i_penable, i_pwrite, i_crc_busy, i_mpy_busy, i_aes_busy, i_dma_trig, i_wake_event} = '0;
        {i_paddr, i_pwdata, i_periph_waiting, i_resetn, slow, mismatches, check_count} = '0;
        n = $urandom(9);
        repeat (2) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        rd(8'h00, 33'h0, '1);
        rd(8'h04, 33'h700, 33'h1000007C7);
        rd(8'h08, 33'h100000000, '1);
        $display("test reset done");
        foreach (tbl[k]) begin
            s = $urandom_range(0, 7);
            v = tbl[k][15:0];
            if (k == 5) v[15:8] = 8'($urandom_range(0, 255));
            i_periph_waiting <= tbl[k][19] ? 8'h01 << s : 8'h00;
            apb(1'b1, 8'h10 + 8'(4 * s), {16'h0, v});
            @(posedge i_ref_clk);
            rd(8'h10 + 8'(4 * s), {17'h0, v}, '1);
            rd(8'h04, {22'h0, tbl[k][18:16], 8'h0}, 33'h700);
            apb(1'b1, 8'h10 + 8'(4 * s), 32'h0);
        end
        i_periph_waiting <= 8'h00;
        $display("test classify done");
        apb(1'b1, 8'h10, 32'h48);
        apb(1'b1, 8'h00, 32'h4);
        wait_mode(3'h2);
        rd(8'h04, 33'h242, 33'h7C7);
        pulse(1'b0);
        repeat (150) @(posedge i_ref_clk);
        wait_mode(3'h2);
        apb(1'b1, 8'h10, 32'h0);
        to_active();
        $display("test demote done");
        for (int b = 0; b < 3; b++) begin
            {i_aes_busy, i_mpy_busy, i_crc_busy} <= 3'(1 << b);
            apb(1'b1, 8'h00, 32'(3 + b));
            repeat (20) @(posedge i_ref_clk);
            rd(8'h04, 33'h80, 33'h87);
            {i_aes_busy, i_mpy_busy, i_crc_busy} <= 3'h0;
            wait_mode(3'(3 + b));
            to_active();
        end
        $display("test postpone done");
        slow <= 1'b1;
        apb(1'b1, 8'h00, 32'hC);
        wait_mode(3'h4);
        pulse(1'b1);
        wait_hi(o_dma_go);
        check(33'({o_dma_go, o_mode}), 33'hC, "dma excursion");
        repeat (40) @(posedge i_ref_clk);
        check(33'({o_dma_go, o_mode}), 33'h4, "dma return");
        pulse(1'b0);
        wait_hi(o_cpu_run);
        check(33'(n + 3 >= lpmarb_pkg::FRAM_WAKE_CYC), 33'h1, "fram wake delay");
        repeat (40) @(posedge i_ref_clk);
        wait_mode(3'h4);
        slow <= 1'b0;
        to_active();
        $display("test dma done");
        apb(1'b1, 8'h00, 32'h7);
        wait_mode(3'h7);
        @(posedge i_ref_clk);
        check(33'({o_core_supply_on, o_aux_clk_en, o_fast_clk_en, o_fram_on}), 33'h0, "shutdown");
        pulse(1'b0);
        wait_hi(o_core_reset);
        check(33'(o_core_reset), 33'h1, "core reset");
        wait_mode(3'h0);
        rd(8'h00, 33'h0, '1);
        $display("test shutdown done");
        results();
    end
endmodule : tb_top
`default_nettype wire
